//--- pkg/regfile_pkg.sv
/*
  Shared constants, types and helpers for the general register file
  with its register-zero trace behaviour.
  Assumes a 64-bit word machine with 8-bit register designators.
*/
`default_nettype none
package regfile_pkg;
  localparam int unsigned REG_COUNT  = 256;
  localparam int unsigned DESIG_W    = 8;
  localparam int unsigned WORD_W     = 64;
  localparam int unsigned MEM_ADDR_W = 48;
  localparam int unsigned TRACE_W    = 48;
  // Branch address field, low end; bits above it are left zero
  localparam int unsigned TRACE_LSB  = 0;

  localparam logic [7:0]  DESIG_ZERO  = 8'h00;
  localparam logic [7:0]  DESIG_LAST  = 8'hff;
  localparam logic [63:0] MZERO_64    = 64'h8000_0000_0000_0000;
  localparam logic [63:0] MZERO_32    = 64'h0000_0000_8000_0000;
  localparam logic [63:0] TRACE_RESET = 64'h0000_0000_0000_0000;
  localparam logic        SPACE_ABS   = 1'b0;
  localparam logic        SPACE_VIRT  = 1'b1;

  // Operand class that decode attaches to each read
  typedef enum logic [2:0] {
    CLS_MACHINE, CLS_ALLZERO, CLS_USED, CLS_CTRL,
    CLS_ONES, CLS_RAW, CLS_ADDR, CLS_LEN
  } opnd_cls_t;

  typedef struct packed {
    logic no_ctrl;
    logic zero_addr;
    logic zero_len;
  } zero_flags_t;

  typedef struct packed {
    logic [WORD_W-1:0] data;
    zero_flags_t       flags;
  } operand_t;

  typedef struct packed {
    logic               en;
    logic [DESIG_W-1:0] desig;
    opnd_cls_t          cls;
  } rd_req_t;

  typedef struct packed {
    logic               en;
    logic [DESIG_W-1:0] desig;
    logic [WORD_W-1:0]  data;
  } wr_req_t;

  typedef struct packed {
    logic                  req;
    logic                  we;
    logic                  space;
    logic [MEM_ADDR_W-1:0] addr;
    logic [WORD_W-1:0]     wdata;
  } mem_cmd_t;

  typedef struct packed {
    logic              ack;
    logic [WORD_W-1:0] rdata;
  } mem_rsp_t;

  typedef struct packed {
    logic               taken;
    logic [TRACE_W-1:0] addr;
  } branch_t;

  function automatic logic is_zero_desig(input logic [DESIG_W-1:0] d);
    return d == DESIG_ZERO;
  endfunction

  function automatic logic [MEM_ADDR_W-1:0] area_addr(
    input logic [MEM_ADDR_W-1:0] base,
    input logic [DESIG_W-1:0]    idx);
    return base + {{(MEM_ADDR_W-DESIG_W){1'b0}}, idx};
  endfunction

  function automatic logic [WORD_W-1:0] trace_word(
    input logic [TRACE_W-1:0] a);
    logic [WORD_W-1:0] w;
    w = '0;
    w[TRACE_LSB +: TRACE_W] = a;
    return w;
  endfunction
endpackage
`default_nettype wire

//--- src/reg_array.sv
/*
  Storage for the general registers: one write port, two read
  ports with registered read data.
  Assumes the caller never relies on write-then-read in one cycle.
*/
`timescale 1ns/100ps
`default_nettype none
module reg_array #(
  parameter int unsigned DEPTH = 256,
  parameter int unsigned WIDTH = 64,
  parameter int unsigned AW    = 8
) (
  input  wire logic             core_clk_i,
  input  wire logic             rst_i,
  input  wire logic [AW-1:0]    rd_a_addr_i,
  input  wire logic [AW-1:0]    rd_b_addr_i,
  output logic      [WIDTH-1:0] rd_a_data_o,
  output logic      [WIDTH-1:0] rd_b_data_o,
  input  wire logic             we_i,
  input  wire logic [AW-1:0]    wr_addr_i,
  input  wire logic [WIDTH-1:0] wr_data_i
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge core_clk_i) begin
    if (we_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_a_data_o <= '0;
      rd_b_data_o <= '0;
    end else begin
      rd_a_data_o <= mem[rd_a_addr_i];
      rd_b_data_o <= mem[rd_b_addr_i];
    end
  end
endmodule // reg_array
`default_nettype wire

//--- src/zero_subst.sv
/*
  Substitute operand for a read of designator zero, chosen by the
  operand class of the read.
  Assumes decode supplies the class; purely combinational.
*/
`timescale 1ns/100ps
`default_nettype none
module zero_subst (
  input  wire regfile_pkg::opnd_cls_t cls_i,
  input  wire logic                   mode64_i,
  input  wire logic [63:0]            trace_i,
  output var  regfile_pkg::operand_t  opnd_o
);
  always_comb begin
    opnd_o = '0;
    unique case (cls_i)
      regfile_pkg::CLS_MACHINE: begin
        opnd_o.data = mode64_i ? regfile_pkg::MZERO_64  // [RQ13] [RQ19]
                               : regfile_pkg::MZERO_32;
      end
      regfile_pkg::CLS_ALLZERO,
      regfile_pkg::CLS_USED: begin
        opnd_o.data = '0;
      end
      regfile_pkg::CLS_CTRL: begin
        opnd_o.flags.no_ctrl = 1'b1;
      end
      regfile_pkg::CLS_ONES: begin
        opnd_o.data = '1;
      end
      regfile_pkg::CLS_RAW: begin
        opnd_o.data = trace_i;
      end
      regfile_pkg::CLS_ADDR: begin
        opnd_o.flags.zero_addr = 1'b1;
      end
      regfile_pkg::CLS_LEN: begin
        opnd_o.flags.zero_len = 1'b1;
      end
    endcase
  end
endmodule // zero_subst
`default_nettype wire

//--- src/cpu_register_file_trace_zero.sv
/*
  General register file of 256 words with register zero acting as
  branch trace, exchange save/restore and register swap sequencing.
  Assumes execution logic stalls operand reads, writes and branches
  while busy_o is high and keeps requests stable until the answer.
*/
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// RQ1: 256 registers, each picked directly by an 8-bit designator.
// RQ2: Exchange stores all registers to first 256 words, address zero up.
// RQ3: Programs must not touch their saved register area as memory.
// RQ4: Register zero tracks taken branches only in 64-bit mode.
// RQ5: Trace word holds branch address low 48 bits; top 16 undefined.
// RQ6: Monitor to job: trace to absolute zero, load trace from virtual.
// RQ7: Job to monitor: trace to virtual zero, load trace from absolute.
// RQ8: Shared file: both zero words get trace, trace itself unchanged.
// RQ9: Swap covering register zero stores trace but leaves it unchanged.
// RQ10: The two indexed transfers read register zero as real trace data.
// RQ11: Maintenance reads trace by forcing a store then reading word zero.
// RQ12: Register zero source gives machine zero, or zeros for descriptors.
// RQ13: Machine zero is 8000..0 in 64-bit mode, 8000 0000 in 32-bit.
// RQ14: Writes to register zero are executed but the result is dropped.
// RQ15: Zero address may be illegal; zero field length may be undefined.
// RQ16: Control vector from register zero means no control vector.
// RQ17: Some designator positions get an all-ones mask from register zero.
// RQ18: Partly used operand gets zeros in its used portion.
// RQ19: Broadcast constant from register zero is machine zero.
// RQ20: Per-port mux on designator zero and class hides the trace.
// RQ21: Trace loads the branch address in the cycle the branch resolves.
module cpu_register_file_trace_zero (
  input  wire logic                   core_clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   mode64_i,
  input  wire logic                   job_mode_i,
  input  wire regfile_pkg::rd_req_t   rd_a_i,
  input  wire regfile_pkg::rd_req_t   rd_b_i,
  output var  regfile_pkg::operand_t  opnd_a_o,
  output var  regfile_pkg::operand_t  opnd_b_o,
  input  wire regfile_pkg::wr_req_t   wr_i,
  input  wire regfile_pkg::branch_t   branch_i,
  input  wire logic                   xchg_i,
  input  wire logic                   xchg_to_job_i,
  input  wire logic                   common_file_i,
  input  wire logic                   swap_i,
  input  wire logic [7:0]             swap_first_i,
  input  wire logic [7:0]             swap_last_i,
  input  wire logic [47:0]            swap_base_i,
  output var  regfile_pkg::mem_cmd_t  mem_cmd_o,
  input  wire regfile_pkg::mem_rsp_t  mem_rsp_i,
  output logic                        busy_o,
  output logic [63:0]                 trace_o
);
  typedef enum logic [1:0] {S_IDLE, S_READ, S_STORE, S_LOAD} seq_t;
  typedef enum logic [1:0] {P2_NONE, P2_LOAD, P2_STORE} pass2_t;

  typedef struct packed {
    seq_t                  st;
    pass2_t                pass2;
    logic                  second;
    logic                  skip0;
    logic [7:0]            idx;
    logic [7:0]            first;
    logic [7:0]            last;
    logic                  space;
    logic                  space2;
    logic [47:0]           base;
    logic [63:0]           trace;
    logic [1:0]            zero_rd;
    regfile_pkg::operand_t subst_a;
    regfile_pkg::operand_t subst_b;
  } state_t;

  localparam state_t STATE_RESET = '{
    st:    S_IDLE,
    pass2: P2_NONE,
    trace: regfile_pkg::TRACE_RESET,
    default: '0
  };

  state_t                state_reg;
  state_t                state_next;
  logic                  busy;
  logic                  step;
  logic                  ram_we;
  logic [7:0]            ram_waddr;
  logic [63:0]           ram_wdata;
  logic [7:0]            ram_a_addr;
  logic [63:0]           ram_a_q;
  logic [63:0]           ram_b_q;
  regfile_pkg::operand_t subst_a;
  regfile_pkg::operand_t subst_b;
  regfile_pkg::mem_cmd_t mem_cmd;

  assign busy = state_reg.st != S_IDLE;
  // Sequencer borrows read port A while busy
  assign ram_a_addr = busy ? state_reg.idx : rd_a_i.desig;

  reg_array #(
    .DEPTH (regfile_pkg::REG_COUNT),
    .WIDTH (regfile_pkg::WORD_W),
    .AW    (regfile_pkg::DESIG_W)
  ) u_array (                                     // [RQ1]
    .core_clk_i  (core_clk_i),
    .rst_i       (rst_i),
    .rd_a_addr_i (ram_a_addr),
    .rd_b_addr_i (rd_b_i.desig),
    .rd_a_data_o (ram_a_q),
    .rd_b_data_o (ram_b_q),
    .we_i        (ram_we),
    .wr_addr_i   (ram_waddr),
    .wr_data_i   (ram_wdata)
  );

  zero_subst u_subst_a (
    .cls_i    (rd_a_i.cls),
    .mode64_i (mode64_i),
    .trace_i  (state_reg.trace),
    .opnd_o   (subst_a)
  );

  zero_subst u_subst_b (
    .cls_i    (rd_b_i.cls),
    .mode64_i (mode64_i),
    .trace_i  (state_reg.trace),
    .opnd_o   (subst_b)
  );

  always_comb begin
    state_next = state_reg;
    step       = 1'b0;
    ram_we     = 1'b0;
    ram_waddr  = wr_i.desig;
    ram_wdata  = wr_i.data;
    mem_cmd    = '0;

    // Substitute is captured alongside the array read
    state_next.zero_rd[0] = rd_a_i.en
      && regfile_pkg::is_zero_desig(rd_a_i.desig);  // [RQ20]
    state_next.zero_rd[1] = rd_b_i.en
      && regfile_pkg::is_zero_desig(rd_b_i.desig);  // [RQ20]
    state_next.subst_a = subst_a;  // [RQ12] [RQ15] [RQ16] [RQ17]
    state_next.subst_b = subst_b;  // [RQ18] [RQ19] [RQ10]

    if (!busy && wr_i.en
        && !regfile_pkg::is_zero_desig(wr_i.desig)) begin
      ram_we = 1'b1;  // [RQ14]
    end
    if (!busy && branch_i.taken && mode64_i) begin
      state_next.trace =
        regfile_pkg::trace_word(branch_i.addr);  // [RQ4] [RQ5] [RQ21]
    end

    unique case (state_reg.st)
      S_IDLE: begin
        state_next.second = 1'b0;
        state_next.base   = '0;
        state_next.skip0  = 1'b0;
        state_next.idx    = regfile_pkg::DESIG_ZERO;
        state_next.first  = regfile_pkg::DESIG_ZERO;
        if (xchg_i) begin
          state_next.st = S_READ;
          if (common_file_i) begin
            // Only the zero words change; trace kept
            state_next.last   = regfile_pkg::DESIG_ZERO;  // [RQ8]
            state_next.pass2  = P2_STORE;
            state_next.space  = regfile_pkg::SPACE_ABS;
            state_next.space2 = regfile_pkg::SPACE_VIRT;
          end else begin
            state_next.last   = regfile_pkg::DESIG_LAST;  // [RQ2]
            state_next.pass2  = P2_LOAD;
            state_next.space  = xchg_to_job_i
              ? regfile_pkg::SPACE_ABS
              : regfile_pkg::SPACE_VIRT;  // [RQ6] [RQ7]
            state_next.space2 = xchg_to_job_i
              ? regfile_pkg::SPACE_VIRT
              : regfile_pkg::SPACE_ABS;  // [RQ6] [RQ7]
          end
        end else if (swap_i) begin
          state_next.st     = S_READ;
          state_next.idx    = swap_first_i;
          state_next.first  = swap_first_i;
          state_next.last   = swap_last_i;
          state_next.base   = swap_base_i;
          state_next.pass2  = P2_LOAD;
          state_next.skip0  = 1'b1;  // [RQ9]
          state_next.space  = job_mode_i ? regfile_pkg::SPACE_VIRT
                                         : regfile_pkg::SPACE_ABS;
          state_next.space2 = state_next.space;
        end
      end
      S_READ: begin
        state_next.st = S_STORE;
      end
      S_STORE: begin
        mem_cmd.req   = 1'b1;
        mem_cmd.we    = 1'b1;
        mem_cmd.space = state_reg.space;
        mem_cmd.addr  = regfile_pkg::area_addr(state_reg.base,
                                               state_reg.idx);
        // Word zero is always the live trace value
        mem_cmd.wdata = regfile_pkg::is_zero_desig(state_reg.idx)
          ? state_reg.trace : ram_a_q;  // [RQ2] [RQ9] [RQ11]
        step = mem_rsp_i.ack;
      end
      S_LOAD: begin
        if (state_reg.skip0
            && regfile_pkg::is_zero_desig(state_reg.idx)) begin
          step = 1'b1;  // [RQ9]
        end else begin
          mem_cmd.req   = 1'b1;
          mem_cmd.space = state_reg.space;
          mem_cmd.addr  = regfile_pkg::area_addr(state_reg.base,
                                                 state_reg.idx);
          step = mem_rsp_i.ack;
          if (mem_rsp_i.ack) begin
            if (regfile_pkg::is_zero_desig(state_reg.idx)) begin
              state_next.trace = mem_rsp_i.rdata;  // [RQ6] [RQ7]
            end else begin
              ram_we    = 1'b1;
              ram_waddr = state_reg.idx;
              ram_wdata = mem_rsp_i.rdata;
            end
          end
        end
      end
    endcase

    if (step) begin
      if (state_reg.idx == state_reg.last) begin
        if (state_reg.second || state_reg.pass2 == P2_NONE) begin
          state_next.st = S_IDLE;
        end else begin
          state_next.second = 1'b1;
          state_next.idx    = state_reg.first;
          state_next.space  = state_reg.space2;
          state_next.st     = (state_reg.pass2 == P2_LOAD)
            ? S_LOAD : S_READ;
        end
      end else begin
        state_next.idx = 8'(state_reg.idx + 8'h01);
        state_next.st  = (state_reg.st == S_LOAD) ? S_LOAD : S_READ;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= STATE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  always_comb begin
    opnd_a_o = state_reg.zero_rd[0] ? state_reg.subst_a
             : '{data: ram_a_q, flags: '0};  // [RQ20]
    opnd_b_o = state_reg.zero_rd[1] ? state_reg.subst_b
             : '{data: ram_b_q, flags: '0};  // [RQ20]
  end

  assign mem_cmd_o = mem_cmd;
  assign busy_o    = busy;
  assign trace_o   = state_reg.trace;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_zero_rd(regfile_pkg::opnd_cls_t c);
    rd_a_i.en && !busy && rd_a_i.cls == c
      && rd_a_i.desig == regfile_pkg::DESIG_ZERO;
  endsequence

  sequence s_xchg_go;
    xchg_i && !busy && !common_file_i && xchg_to_job_i;
  endsequence

  sequence s_first_store;
    !mem_cmd_o.req ##1 (mem_cmd_o.req && mem_cmd_o.we
      && mem_cmd_o.addr == '0
      && mem_cmd_o.space == regfile_pkg::SPACE_ABS
      && mem_cmd_o.wdata == trace_o);
  endsequence

  chk_machine_zero_64: assert property ( // [RQ12] [RQ13]
    s_zero_rd(regfile_pkg::CLS_MACHINE) ##0 mode64_i
      |=> opnd_a_o.data == regfile_pkg::MZERO_64)
    else $error("machine zero wrong in 64-bit mode");

  chk_machine_zero_32: assert property ( // [RQ13] [RQ19]
    s_zero_rd(regfile_pkg::CLS_MACHINE) ##0 !mode64_i
      |=> opnd_a_o.data == regfile_pkg::MZERO_32)
    else $error("machine zero wrong in 32-bit mode");

  chk_raw_trace_read: assert property ( // [RQ10]
    s_zero_rd(regfile_pkg::CLS_RAW)
      |=> opnd_a_o.data == $past(state_reg.trace))
    else $error("indexed read of register zero missed trace");

  chk_no_ctrl_vector: assert property ( // [RQ16]
    s_zero_rd(regfile_pkg::CLS_CTRL)
      |=> opnd_a_o.flags.no_ctrl && opnd_a_o.data == '0)
    else $error("control vector not suppressed");

  chk_ones_mask: assert property ( // [RQ17]
    s_zero_rd(regfile_pkg::CLS_ONES) |=> &opnd_a_o.data)
    else $error("mask from register zero not all ones");

  chk_used_zeros: assert property ( // [RQ18] [RQ12]
    s_zero_rd(regfile_pkg::CLS_USED) or s_zero_rd(regfile_pkg::CLS_ALLZERO)
      |=> opnd_a_o.data == '0)
    else $error("zero operand not all zeros");

  chk_zero_addr_flag: assert property ( // [RQ15]
    s_zero_rd(regfile_pkg::CLS_ADDR) |=> opnd_a_o.flags.zero_addr)
    else $error("zero address not flagged");

  chk_zero_write_drop: assert property ( // [RQ14]
    ram_we |-> ram_waddr != regfile_pkg::DESIG_ZERO)
    else $error("write reached register zero storage");

  chk_branch_trace: assert property ( // [RQ21] [RQ5]
    branch_i.taken && mode64_i && !busy
      |=> trace_o == regfile_pkg::trace_word($past(branch_i.addr)))
    else $error("trace not loaded with branch address");

  chk_trace_32bit: assert property ( // [RQ4]
    !mode64_i && !busy |=> $stable(trace_o))
    else $error("trace changed outside 64-bit mode");

  chk_swap_keeps_trace: assert property ( // [RQ9]
    busy && state_reg.skip0 |=> $stable(trace_o))
    else $error("swap altered trace register");

  chk_common_keeps_trace: assert property ( // [RQ8]
    busy && state_reg.pass2 == P2_STORE |=> $stable(trace_o))
    else $error("shared-file exchange altered trace");

  chk_exchange_start: assert property ( // [RQ2] [RQ6]
    s_xchg_go |=> s_first_store)
    else $error("exchange did not store trace to absolute zero");

  chk_trace_reload: assert property ( // [RQ6] [RQ7]
    state_reg.st == S_LOAD && !state_reg.skip0 && mem_rsp_i.ack
      && state_reg.idx == regfile_pkg::DESIG_ZERO
      |=> trace_o == $past(mem_rsp_i.rdata))
    else $error("trace not reloaded from saved word zero");
endmodule // cpu_register_file_trace_zero
`default_nettype wire

//--- bench/mem_model.sv
/*
  Memory partner for the register file: absolute and virtual word
  spaces answering the exchange and swap sequencer.
  Assumes word addresses below 512 and one request at a time.
*/
`timescale 1ns/100ps
`default_nettype none
module mem_model (
  input  wire logic                  core_clk_i,
  input  wire logic                  slow_i,
  input  wire regfile_pkg::mem_cmd_t cmd_i,
  output var  regfile_pkg::mem_rsp_t rsp_o
);
  logic [63:0] words [2][512];
  int          wait_cnt;

  initial begin
    rsp_o    = '0;
    wait_cnt = 0;
  end

  // Only the sequencer touches the saved areas
  always @(negedge core_clk_i) begin
    if (rsp_o.ack || !cmd_i.req) begin
      rsp_o.ack   <= 1'b0;
      rsp_o.rdata <= ~rsp_o.rdata;
      wait_cnt    <= 0;
    end else if (wait_cnt >= (slow_i ? 3 : 0)) begin
      rsp_o.ack <= 1'b1;
      if (cmd_i.we) begin
        words[cmd_i.space][cmd_i.addr[8:0]] <= cmd_i.wdata;
        rsp_o.rdata <= ~rsp_o.rdata;
      end else begin
        rsp_o.rdata <= words[cmd_i.space][cmd_i.addr[8:0]];
      end
    end else begin
      rsp_o.rdata <= ~rsp_o.rdata;
      wait_cnt    <= wait_cnt + 1;
    end
  end
endmodule // mem_model
`default_nettype wire

//--- bench/tb_top.sv
/*
  Self-checking bench for the register file with trace register zero.
  Assumes the memory partner model and a 100 MHz clock.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic                  core_clk_i, rst_i, mode64_i, job_mode_i;
  logic                  xchg_i, xchg_to_job_i, common_file_i, swap_i;
  logic                  busy_o, slow;
  logic [7:0]            swap_first_i, swap_last_i;
  logic [47:0]           swap_base_i;
  logic [63:0]           trace_o, mtrace, v;
  logic [63:0]           mreg [256];
  regfile_pkg::rd_req_t  rd_a_i, rd_b_i;
  regfile_pkg::operand_t opnd_a_o, opnd_b_o;
  regfile_pkg::wr_req_t  wr_i;
  regfile_pkg::branch_t  branch_i;
  regfile_pkg::mem_cmd_t mem_cmd_o;
  regfile_pkg::mem_rsp_t mem_rsp_i;
  integer                seed = 32'h03da;
  int                    bad_count, cmp_count, cyc;

  cpu_register_file_trace_zero i_cpu_register_file_trace_zero (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .mode64_i(mode64_i),
    .job_mode_i(job_mode_i), .rd_a_i(rd_a_i), .rd_b_i(rd_b_i),
    .opnd_a_o(opnd_a_o), .opnd_b_o(opnd_b_o), .wr_i(wr_i),
    .branch_i(branch_i), .xchg_i(xchg_i), .xchg_to_job_i(xchg_to_job_i),
    .common_file_i(common_file_i), .swap_i(swap_i),
    .swap_first_i(swap_first_i), .swap_last_i(swap_last_i),
    .swap_base_i(swap_base_i), .mem_cmd_o(mem_cmd_o),
    .mem_rsp_i(mem_rsp_i), .busy_o(busy_o), .trace_o(trace_o));

  mem_model i_mem_model (.core_clk_i(core_clk_i), .slow_i(slow),
    .cmd_i(mem_cmd_o), .rsp_o(mem_rsp_i));

  function automatic logic [63:0] rnd();
    return {$random(seed), $random(seed)};
  endfunction

  task automatic complete_run;
    if (bad_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [63:0] exp,
                     input logic [63:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic rchk(input logic pb, input logic [7:0] d,
                      input regfile_pkg::opnd_cls_t c);
    regfile_pkg::operand_t o;
    logic [63:0]           e;
    logic [2:0]            f;
    e = mreg[d];
    f = 3'h0;
    if (d == 8'h00) begin
      e = '0;
      if (c == regfile_pkg::CLS_MACHINE)
        e = mode64_i ? 64'h8000_0000_0000_0000 : 64'h0000_0000_8000_0000;
      if (c == regfile_pkg::CLS_ONES) e = '1;
      if (c == regfile_pkg::CLS_RAW) e = mtrace;
      if (c == regfile_pkg::CLS_CTRL) f = 3'h4;
      if (c == regfile_pkg::CLS_ADDR) f = 3'h2;
      if (c == regfile_pkg::CLS_LEN) f = 3'h1;
    end
    @(negedge core_clk_i);
    if (pb) rd_b_i = {1'b1, d, c};
    else rd_a_i = {1'b1, d, c};
    @(negedge core_clk_i);
    o = pb ? opnd_b_o : opnd_a_o;
    rd_a_i.en = 1'b0;
    rd_b_i.en = 1'b0;
    chk("opnd_data", e, o.data);
    chk("opnd_flags", {61'h0, f}, {61'h0, o.flags});
  endtask

  task automatic wr(input logic [7:0] d, input logic [63:0] x);
    @(negedge core_clk_i);
    wr_i = {1'b1, d, x};
    if (d != 8'h00) mreg[d] = x;
    @(negedge core_clk_i);
    wr_i.en = 1'b0;
  endtask

  task automatic br(input logic [47:0] a);
    @(negedge core_clk_i);
    branch_i = {1'b1, a};
    if (mode64_i) mtrace = {16'h0000, a};
    @(negedge core_clk_i);
    branch_i.taken = 1'b0;
    chk("trace", mtrace, trace_o);
  endtask

  task automatic run_seq(input logic is_x);
    int n;
    @(negedge core_clk_i);
    if (is_x) xchg_i = 1'b1;
    else swap_i = 1'b1;
    @(negedge core_clk_i);
    xchg_i = 1'b0;
    swap_i = 1'b0;
    chk("busy", 64'h1, {63'h0, busy_o});
    n = 0;
    while (busy_o !== 1'b0 && n < 5000) begin
      @(negedge core_clk_i);
      n++;
    end
    chk("busy_end", 64'h0, {63'h0, busy_o});
  endtask

  task automatic xchg(input logic to_job, input logic common);
    logic [63:0] old_t, keep;
    logic        st, ld;
    st = !to_job;
    ld = to_job;
    old_t = mtrace;
    keep = i_mem_model.words[ld][0];
    xchg_to_job_i = to_job;
    common_file_i = common;
    run_seq(1'b1);
    chk("store_zero", old_t, i_mem_model.words[st][0]);
    if (common) begin
      chk("other_zero", old_t, i_mem_model.words[ld][0]);
    end else begin
      chk("kept_zero", keep, i_mem_model.words[ld][0]);
      for (int i = 1; i < 256; i++) begin
        chk("saved_reg", mreg[i], i_mem_model.words[st][i]);
        mreg[i] = i_mem_model.words[ld][i];
      end
      mtrace = keep;
    end
    chk("trace_xchg", mtrace, trace_o);
    rchk(1'b0, 8'hff, regfile_pkg::CLS_RAW);
    rchk(1'b1, 8'h01, regfile_pkg::CLS_MACHINE);
  endtask

  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      complete_run();
    end
  end

  initial begin
    rst_i = 1'b1;
    {mode64_i, job_mode_i, xchg_i, xchg_to_job_i} = 4'h0;
    {common_file_i, swap_i, slow, swap_first_i, swap_last_i} = '0;
    {swap_base_i, rd_a_i, rd_b_i, wr_i, branch_i} = '0;
    mtrace = '0;
    for (int s = 0; s < 2; s++)
      for (int a = 0; a < 512; a++)
        i_mem_model.words[s][a] = rnd();
    i_mem_model.words[0][0][63:48] = 16'h0000;
    i_mem_model.words[1][0][63:48] = 16'h0000;
    repeat (20) @(negedge core_clk_i);
    rst_i = 1'b0;
    chk("trace_rst", 64'h0, trace_o);
    chk("busy_rst", 64'h0, {63'h0, busy_o});
    for (int i = 0; i < 256; i++) wr(i[7:0], rnd());
    mode64_i = 1'b1;
    v = rnd();
    br(v[47:0]);
    mode64_i = 1'b0;
    v = rnd();
    br(v[47:0]);
    for (int k = 0; k < 32; k++) begin
      mode64_i = k[3];
      rchk(k[4], 8'h00, regfile_pkg::opnd_cls_t'(k[2:0]));
    end
    for (int k = 0; k < 24; k++) begin
      v = rnd();
      rchk(v[8], v[7:0], regfile_pkg::opnd_cls_t'(v[18:16]));
    end
    mode64_i = 1'b1;
    xchg(1'b1, 1'b0);
    slow = 1'b1;
    xchg(1'b0, 1'b0);
    xchg(1'b1, 1'b1);
    xchg(1'b0, 1'b1);
    slow = 1'b0;
    job_mode_i = 1'b1;
    swap_last_i = 8'h03;
    swap_base_i = 48'h0000_0000_0100;
    run_seq(1'b0);
    chk("swap_zero", mtrace, i_mem_model.words[1][256]);
    for (int i = 1; i < 4; i++) begin
      chk("swap_store", mreg[i], i_mem_model.words[1][256 + i]);
      rchk(1'b0, i[7:0], regfile_pkg::CLS_RAW);
    end
    chk("trace_swap", mtrace, trace_o);
    job_mode_i = 1'b0;
    run_seq(1'b0);
    chk("swap_abs_zero", mtrace, i_mem_model.words[0][256]);
    chk("trace_swap_abs", mtrace, trace_o);
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
